// >>> hw/fail_output.sv
// Fail output logic, configuration straps and interrupt pulse output.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module fail_output #(
  parameter int IRQ_WIDTH_CYC = fail_pkg::IRQ_PULSE_WIDTH_CYC,
  parameter int IRQ_GAP_CYC = fail_pkg::IRQ_PULSE_GAP_CYC,
  parameter int STRAP_CYC = fail_pkg::STRAP_FILTER_CYC,
  parameter int TEST_CYC = fail_pkg::TEST_FILTER_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic init_mode,
  input wire logic normal_or_stop,
  input wire logic soft_reset,
  input wire logic irq_event,
  input wire logic wd_fail,
  input wire logic wd_trigger_ok,
  input wire logic thermal_shutdown_stage2,
  input wire logic io_supply_short,
  input wire logic io_supply_overvoltage,
  input wire logic io_supply_undervoltage,
  input wire logic io_supply_uv_ok,
  input wire logic interrupt_out_n_in,
  output logic interrupt_out_n,
  output logic interrupt_out_n_oe_n,
  input wire logic fail_test_in,
  output logic fail_out,
  output logic fail_out_oe_n,
  output logic [1:0] config_index,
  output logic fail_safe_entry,
  output logic test_mode,
  output logic irq
);
  // Register decode used by the write path; the read path decodes addr in its own case statement.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic strap_lvl;
  logic test_lvl;
  logic pulse_n;

  // The strap filter sees the pin at all times, driven or released; its level is used only while Init lasts.
  pin_filter #(.FILTER_CYC(STRAP_CYC), .RESET_LEVEL(1'b0)) u_strap (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(interrupt_out_n_in),
    .level_q(strap_lvl)
  );

  pin_filter #(.FILTER_CYC(TEST_CYC), .RESET_LEVEL(1'b1)) u_test (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(fail_test_in),
    .level_q(test_lvl)
  );

  irq_pulser #(.WIDTH_CYC(IRQ_WIDTH_CYC), .GAP_CYC(IRQ_GAP_CYC)) u_pulse (
    .clk(clk),
    .reset_n(reset_n),
    .enable(normal_or_stop & ~init_mode),
    .event_in(irq_event),
    .pin_n_q(pulse_n)
  );

  // Software state: control bits, mask and sticky interrupt status.
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [fail_pkg::EV_W-1:0] mask_q;
  logic [fail_pkg::EV_W-1:0] mask_d;
  logic [fail_pkg::EV_W-1:0] ist_q;
  logic [fail_pkg::EV_W-1:0] ist_d;
  logic [fail_pkg::EV_W-1:0] events;
  logic [31:0] rdata_d;
  logic irq_d;
  logic wr_stat;

  // Failure tracking state.
  logic [1:0] wd_cnt_q;
  logic [1:0] wd_cnt_d;
  logic wd_latch_q;
  logic wd_latch_d;
  logic [2:0] uv_cnt_q;
  logic [2:0] uv_cnt_d;
  logic flag_q;
  logic flag_d;
  logic cond;
  logic wd_limit;

  // Configuration state.
  logic [1:0] cfg_q;
  logic [1:0] cfg_d;
  logic fs_q;
  logic fs_d;
  logic tm_q;
  logic tm_d;
  logic init_q;
  logic init_d;
  logic cfg_evt;

  assign wr_stat = wr_en & hit(addr, fail_pkg::ADDR_DEV_STATUS);

  // Configuration follows the straps and the select bit for as long as
  // Init lasts; it freezes when Init ends, so a later soft reset into
  // Init picks up the pins and the select bit afresh.
  always_comb begin
    init_d = init_mode;
    cfg_d = cfg_q;
    fs_d = fs_q;
    tm_d = tm_q;
    if (init_q) begin
      // Index 0..3 stands for configurations 1..4.
      cfg_d = {~ctrl_q[fail_pkg::CTRL_CFG_SEL_BIT], ~strap_lvl};
      fs_d = ~strap_lvl;
      tm_d = ~test_lvl;
    end
  end

  assign cfg_evt = init_q & ~init_mode;

  // The watchdog failure limit comes from the select bit held in the
  // frozen configuration: one failure for configs 1/2, two for 3/4.
  assign wd_limit = cfg_q[1] ? (wd_cnt_q == 2'h1)
    : (wd_cnt_q == 2'h0);

  always_comb begin
    wd_cnt_d = wd_cnt_q;
    wd_latch_d = wd_latch_q;
    uv_cnt_d = uv_cnt_q;
    if (wd_fail) begin
      if (wd_limit) begin
        wd_latch_d = 1'b1;
      end else begin
        wd_cnt_d = wd_cnt_q + 2'h1;
      end
    end else if (wd_trigger_ok) begin
      // Only a good trigger lets the watchdog cause go away.
      wd_cnt_d = 2'h0;
      wd_latch_d = 1'b0;
    end
    if (io_supply_undervoltage) begin
      if (uv_cnt_q != fail_pkg::UV_FAIL_COUNT) begin
        uv_cnt_d = uv_cnt_q + 3'h1;
      end
    end else if (io_supply_uv_ok) begin
      uv_cnt_d = 3'h0;
    end
  end

  // Every listed cause counts, whether or not it leads to fail-safe; overvoltage counts only with its enable bit set.
  assign cond = thermal_shutdown_stage2 | io_supply_short | wd_latch_q
    | (io_supply_overvoltage & ctrl_q[fail_pkg::CTRL_OV_RST_EN_BIT])
    | (uv_cnt_q == fail_pkg::UV_FAIL_COUNT);

  // A present cause always wins over a software clear, so the flag
  // cannot be dropped under a live failure.
  always_comb begin
    flag_d = flag_q;
    if (wr_stat && wdata[fail_pkg::STAT_FAIL_ACTIVE_BIT]) begin
      flag_d = 1'b0;
    end
    if (cond) begin
      flag_d = 1'b1;
    end
  end

  assign events[fail_pkg::EV_FAIL_ON] = flag_d & ~flag_q;
  assign events[fail_pkg::EV_WD_FAIL] = wd_fail;
  assign events[fail_pkg::EV_UV_LIMIT] = uv_cnt_d == fail_pkg::UV_FAIL_COUNT
    && uv_cnt_q != fail_pkg::UV_FAIL_COUNT;
  assign events[fail_pkg::EV_CONFIG] = cfg_evt;

  // Register writes; new events win over a write-one clear.
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    ist_d = ist_q;
    if (wr_en && hit(addr, fail_pkg::ADDR_CTRL)) begin
      ctrl_d = wdata[1:0];
    end
    if (wr_en && hit(addr, fail_pkg::ADDR_IRQ_MASK)) begin
      mask_d = wdata[fail_pkg::EV_W-1:0];
    end
    if (wr_en && hit(addr, fail_pkg::ADDR_IRQ_STATUS)) begin
      ist_d = ist_q & ~wdata[fail_pkg::EV_W-1:0];
    end
    ist_d = ist_d | events;
    if (soft_reset) begin
      ctrl_d = fail_pkg::CTRL_RESET;
      mask_d = fail_pkg::IRQ_MASK_RESET;
    end
    irq_d = |(ist_d & mask_d);
  end

  // Read data stands in the cycle after the strobe; unmapped reads zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        fail_pkg::ADDR_CTRL: rdata_d[1:0] = ctrl_q;
        fail_pkg::ADDR_DEV_STATUS: begin
          rdata_d[fail_pkg::STAT_FAIL_ACTIVE_BIT] = flag_q;
          rdata_d[fail_pkg::STAT_CONFIG_LSB +: 2] = cfg_q;
          rdata_d[fail_pkg::STAT_FAIL_SAFE_BIT] = fs_q;
          rdata_d[fail_pkg::STAT_TEST_MODE_BIT] = tm_q;
          rdata_d[fail_pkg::STAT_COND_BIT] = cond;
          rdata_d[fail_pkg::STAT_WD_LATCH_BIT] = wd_latch_q;
        end
        fail_pkg::ADDR_IRQ_STATUS: rdata_d[fail_pkg::EV_W-1:0] = ist_q;
        fail_pkg::ADDR_IRQ_MASK: rdata_d[fail_pkg::EV_W-1:0] = mask_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // All pin and status outputs are registered.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= fail_pkg::CTRL_RESET;
      mask_q <= fail_pkg::IRQ_MASK_RESET;
      ist_q <= '0;
      irq <= 1'b0;
      rdata <= 32'h0000_0000;
      wd_cnt_q <= 2'h0;
      wd_latch_q <= 1'b0;
      uv_cnt_q <= 3'h0;
      flag_q <= 1'b0;
      cfg_q <= 2'h0;
      fs_q <= 1'b0;
      tm_q <= 1'b0;
      init_q <= 1'b1;
      interrupt_out_n <= 1'b1;
      interrupt_out_n_oe_n <= 1'b1;
      fail_out <= 1'b1;
      fail_out_oe_n <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      ist_q <= ist_d;
      irq <= irq_d;
      rdata <= rdata_d;
      wd_cnt_q <= wd_cnt_d;
      wd_latch_q <= wd_latch_d;
      uv_cnt_q <= uv_cnt_d;
      flag_q <= flag_d;
      cfg_q <= cfg_d;
      fs_q <= fs_d;
      tm_q <= tm_d;
      init_q <= init_d;
      // The interrupt driver is released in Init so the strap is readable.
      interrupt_out_n <= pulse_n;
      interrupt_out_n_oe_n <= init_d;
      // Low-side switch: drives low while the flag is set, else released.
      fail_out <= ~flag_d;
      fail_out_oe_n <= ~flag_d;
    end
  end

  assign config_index = cfg_q;
  assign fail_safe_entry = fs_q;
  assign test_mode = tm_q;
endmodule

// >>> common/fail_pkg.sv
// Shared constants for the fail output and interrupt pulse block.
package fail_pkg;
  // Clock rate and documented times in their own units.
  localparam int CLK_FREQ_MHZ = 40;
  localparam int IRQ_PULSE_WIDTH_US = 100;
  localparam int IRQ_PULSE_GAP_US = 100;
  localparam int STRAP_FILTER_TIME_US = 8;
  localparam int TEST_INPUT_FILTER_TIME_US = 64;
  // Derived cycle counts; all figures are whole cycles at 40 MHz.
  localparam int IRQ_PULSE_WIDTH_CYC = IRQ_PULSE_WIDTH_US * CLK_FREQ_MHZ;
  localparam int IRQ_PULSE_GAP_CYC = IRQ_PULSE_GAP_US * CLK_FREQ_MHZ;
  localparam int STRAP_FILTER_CYC = STRAP_FILTER_TIME_US * CLK_FREQ_MHZ;
  localparam int TEST_FILTER_CYC = TEST_INPUT_FILTER_TIME_US * CLK_FREQ_MHZ;
  // Undervoltage detections in a row that force the fail output.
  localparam logic [2:0] UV_FAIL_COUNT = 3'h4;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEV_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // Control register fields.
  localparam int CTRL_CFG_SEL_BIT = 0;
  localparam int CTRL_OV_RST_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Device status fields.
  localparam int STAT_FAIL_ACTIVE_BIT = 0;
  localparam int STAT_CONFIG_LSB = 1;
  localparam int STAT_FAIL_SAFE_BIT = 3;
  localparam int STAT_TEST_MODE_BIT = 4;
  localparam int STAT_COND_BIT = 5;
  localparam int STAT_WD_LATCH_BIT = 6;
  // Interrupt status and mask fields.
  localparam int EV_FAIL_ON = 0;
  localparam int EV_WD_FAIL = 1;
  localparam int EV_UV_LIMIT = 2;
  localparam int EV_CONFIG = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
endpackage

// >>> hw/pin_filter.sv
// Two-stage synchroniser followed by a stable-level filter for one pin.
`timescale 1ns/1ps
module pin_filter #(
  parameter int FILTER_CYC = 320,
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic level_q
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILTER_CYC - 1);

  logic sync1_q;
  logic sync2_q;
  logic level_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // The new level is accepted only after it has held for the full count.
  always_comb begin
    level_d = level_q;
    cnt_d = '0;
    if (sync2_q != level_q) begin
      if (cnt_q == LAST) begin
        level_d = sync2_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // The first stage feeds the second stage only.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= RESET_LEVEL;
      sync2_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
      cnt_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> hw/irq_pulser.sv
// Active-low interrupt pulse generator with a guaranteed high gap.
`timescale 1ns/1ps
module irq_pulser #(
  parameter int WIDTH_CYC = 4000,
  parameter int GAP_CYC = 4000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic event_in,
  output logic pin_n_q
);
  localparam int MAXC = (WIDTH_CYC > GAP_CYC) ? WIDTH_CYC : GAP_CYC;
  localparam int CW = $clog2(MAXC + 1);
  localparam logic [CW-1:0] W_LAST = CW'(WIDTH_CYC - 1);
  localparam logic [CW-1:0] G_LAST = CW'(GAP_CYC - 1);

  typedef enum logic [1:0] {IDLE, PULSE, GAP} pulse_state_e;
  pulse_state_e state_q;
  pulse_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic pend_q;
  logic pend_d;
  logic pin_n_d;

  // Events that arrive during a pulse or gap wait for the gap to end.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pend_d = pend_q | (event_in & enable);
    pin_n_d = 1'b1;
    case (state_q)
      IDLE: begin
        // A pulse never starts once the mode has left Normal or Stop.
        if (pend_d && enable) begin
          state_d = PULSE;
          pend_d = 1'b0;
          cnt_d = '0;
          pin_n_d = 1'b0;
        end
      end
      PULSE: begin
        pin_n_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == W_LAST) begin
          state_d = GAP;
          cnt_d = '0;
          pin_n_d = 1'b1;
        end
      end
      GAP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == G_LAST) begin
          state_d = IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        state_d = IDLE;
        cnt_d = '0;
      end
    endcase
    if (!enable) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= IDLE;
      cnt_q <= '0;
      pend_q <= 1'b0;
      pin_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      pin_n_q <= pin_n_d;
    end
  end
endmodule

// >>> tb/fail_output_props.sv
// Port-level checks for the fail output block, bound into the design.
`timescale 1ns/1ps
module fail_output_checker #(
  parameter int IRQ_WIDTH_CYC = 20,
  parameter int IRQ_GAP_CYC = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic init_mode,
  input wire logic normal_or_stop,
  input wire logic irq_event,
  input wire logic thermal_shutdown_stage2,
  input wire logic io_supply_short,
  input wire logic interrupt_out_n,
  input wire logic interrupt_out_n_oe_n,
  input wire logic fail_out,
  input wire logic fail_out_oe_n
);
  localparam logic [15:0] WID = 16'(IRQ_WIDTH_CYC);
  localparam logic [15:0] GAP = 16'(IRQ_GAP_CYC);
  localparam logic [15:0] SAT = 16'(IRQ_GAP_CYC + 4);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] low_q, low_d, high_q, high_d;
  logic cause_w, clear_w;
  // The gap count saturates above the minimum so idle is easy to spot.
  always_comb begin
    low_d = interrupt_out_n ? 16'h0 : low_q + 16'h1;
    high_d = high_q;
    if (!interrupt_out_n) high_d = 16'h0;
    else if (high_q < SAT) high_d = high_q + 16'h1;
  end
  always_ff @(posedge clk) begin
    low_q <= reset_n ? low_d : 16'h0;
    high_q <= reset_n ? high_d : SAT;
  end
  // Cause and clear decodes shared by the fail checks.
  assign cause_w = thermal_shutdown_stage2 || io_supply_short;
  assign clear_w = wr_en && addr == fail_pkg::ADDR_DEV_STATUS && wdata[0];
  sequence s_ev_taken;
    irq_event && normal_or_stop && !init_mode && high_q == SAT
    ##1 normal_or_stop && !init_mode;
  endsequence
  chk_cause_sets: assert property (cause_w |=> !fail_out_oe_n)
    else $error("fail driver not on after a cause");
  chk_release_needs: assert property (
    $rose(fail_out_oe_n) |-> $past(clear_w) && !$past(cause_w))
    else $error("fail driver released without a clean clear");
  chk_fail_pair: assert property (fail_out == fail_out_oe_n)
    else $error("fail pin level and enable disagree");
  chk_irq_width: assert property (
    $rose(interrupt_out_n) |-> low_q == WID)
    else $error("interrupt pulse width wrong");
  chk_irq_bound: assert property (
    !interrupt_out_n |-> low_q < WID)
    else $error("interrupt pulse too long");
  chk_irq_gap: assert property (
    $fell(interrupt_out_n) |-> high_q >= GAP)
    else $error("interrupt gap too short");
  chk_irq_start: assert property (
    s_ev_taken |=> !interrupt_out_n)
    else $error("interrupt pulse did not start");
  chk_pin_release: assert property (init_mode |=> interrupt_out_n_oe_n)
    else $error("interrupt pin driven while sensing strap");
  chk_pin_drive: assert property (!init_mode |=> !interrupt_out_n_oe_n)
    else $error("interrupt pin not driven outside init");
endmodule
bind fail_output fail_output_checker #(
  .IRQ_WIDTH_CYC(IRQ_WIDTH_CYC),
  .IRQ_GAP_CYC(IRQ_GAP_CYC)
) i_chk (
  .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .init_mode(init_mode), .normal_or_stop(normal_or_stop),
  .irq_event(irq_event), .thermal_shutdown_stage2(thermal_shutdown_stage2),
  .io_supply_short(io_supply_short), .interrupt_out_n(interrupt_out_n),
  .interrupt_out_n_oe_n(interrupt_out_n_oe_n), .fail_out(fail_out), .fail_out_oe_n(fail_out_oe_n)
);

// >>> tb/fail_partner.sv
// Board model: strap resistor, test jumper and the fail load.
`timescale 1ns/1ps
module fail_partner (
  input wire logic strap_pull_up,
  input wire logic test_jumper_low,
  input wire logic interrupt_out_n,
  input wire logic interrupt_out_n_oe_n,
  input wire logic fail_out_oe_n,
  output logic interrupt_out_n_in,
  output logic fail_test_in,
  output logic load_on
);
  // A released pin falls to the internal pull-down unless the board fits
  // the pull-up, so the level is never left at a stale driven value.
  assign interrupt_out_n_in = !interrupt_out_n_oe_n ? interrupt_out_n : strap_pull_up;
  // Open-drain fail pin with a load pull-up; a jumper to ground asks for
  // test mode and also shorts the load, so keep it off outside init.
  assign fail_test_in = !fail_out_oe_n ? 1'b0
    : !test_jumper_low;
  assign load_on = !fail_test_in;
endmodule

// >>> tb/fail_output_and_irq_pulse_tb.sv
// Self-checking bench for the fail output and interrupt pulse block.
`timescale 1ns/1ps
module fail_output_and_irq_pulse_tb;
  localparam int W = 20;
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic init_mode = 1'b1, normal_or_stop = 1'b0, pu = 1'b1, tj = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v, rng = 32'hF60B;
  logic [5:0] pls = 6'h0;
  logic [2:0] cs = 3'h0;
  logic interrupt_out_n, interrupt_out_n_oe_n, interrupt_out_n_in, fail_test_in, fail_out;
  logic fail_out_oe_n, fail_safe_entry, test_mode, irq, load_on;
  logic prev_n = 1'b1;
  logic [1:0] config_index;
  int miscompares = 0, samples_checked = 0, pulses = 0, need;
  always #12.5 clk = ~clk;
  // Falling edges of the interrupt pin are counted as pulses.
  always @(posedge clk) begin
    prev_n <= interrupt_out_n;
    if (prev_n === 1'b1 && interrupt_out_n === 1'b0) pulses++;
  end
  fail_output #(.IRQ_WIDTH_CYC(W), .IRQ_GAP_CYC(W), .STRAP_CYC(8),
    .TEST_CYC(16)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .init_mode(init_mode),
    .normal_or_stop(normal_or_stop), .soft_reset(pls[0]),
    .irq_event(pls[5]), .wd_fail(pls[4]), .wd_trigger_ok(pls[3]),
    .thermal_shutdown_stage2(cs[0]), .io_supply_short(cs[1]),
    .io_supply_overvoltage(cs[2]), .io_supply_undervoltage(pls[2]),
    .io_supply_uv_ok(pls[1]), .interrupt_out_n_in(interrupt_out_n_in),
    .interrupt_out_n(interrupt_out_n), .interrupt_out_n_oe_n(interrupt_out_n_oe_n),
    .fail_test_in(fail_test_in), .fail_out(fail_out),
    .fail_out_oe_n(fail_out_oe_n), .config_index(config_index),
    .fail_safe_entry(fail_safe_entry), .test_mode(test_mode), .irq(irq));
  fail_partner i_far (.strap_pull_up(pu), .test_jumper_low(tj),
    .interrupt_out_n(interrupt_out_n), .interrupt_out_n_oe_n(interrupt_out_n_oe_n),
    .fail_out_oe_n(fail_out_oe_n), .interrupt_out_n_in(interrupt_out_n_in),
    .fail_test_in(fail_test_in), .load_on(load_on));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmp_word(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    pls <= m;
    @(posedge clk);
    pls <= 6'h0;
  endtask
  task automatic clr;
    wr(fail_pkg::ADDR_DEV_STATUS, 32'h1);
    wt(1);
  endtask
  // Pin, load and flag must all agree on the fail state.
  task automatic fchk(input logic on);
    cmp_bit("fail_out", !on, fail_out);
    cmp_bit("load_on", on, load_on);
    rd(fail_pkg::ADDR_DEV_STATUS, v);
    cmp_bit("fail_active_flag", on, v[0]);
  endtask
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The whole run needs under a thousand cycles; 30000 cycles is a wide margin.
  initial begin
    #(25.0 * 30000);
    miscompares++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(fail_pkg::ADDR_CTRL, v);
    cmp_word("ctrl", 32'h0, v);
    rd(8'h10, v);
    cmp_word("unmapped", 32'h0, v);
    fchk(1'b0); // No cause after reset
    // Every configuration, with a short strap glitch that must be ignored.
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      init_mode <= 1'b1;
      normal_or_stop <= 1'b0;
      pu <= !c[0];
      tj <= (c == 3);
      pulse(6'h01);
      wr(fail_pkg::ADDR_CTRL, {31'h0, !c[1]});
      pu <= c[0];
      repeat (4) @(posedge clk);
      pu <= !c[0];
      wt(40);
      @(posedge clk);
      init_mode <= 1'b0;
      normal_or_stop <= 1'b1;
      tj <= 1'b0;
      wt(3);
      cmp_word("config_index", 32'(c), {30'h0, config_index});
      cmp_bit("fail_safe_entry", c[0], fail_safe_entry);
      cmp_bit("test_mode", c == 3, test_mode);
      rd(fail_pkg::ADDR_DEV_STATUS, v);
      cmp_word("status", {28'h0, c == 3, c[0], c[1:0]}, v[4:1]);
      need = c[1] ? 2 : 1;
      for (int k = 1; k <= need; k++) begin
        pulse(6'h10);
        wt(2);
        fchk(k == need); // Count of failures
      end
      clr;
      fchk(1'b1); // No good trigger yet
      pulse(6'h08);
      clr;
      fchk(1'b0); // Trigger then clear
    end
    rng = xs(rng);
    wr(fail_pkg::ADDR_CTRL, {rng[31:2], 2'h2});
    rd(fail_pkg::ADDR_CTRL, v);
    cmp_word("ctrl", 32'h2, v);
    // Each level cause in turn, with a clear tried while it is present.
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cs <= 3'h1 << k;
      wt(2);
      fchk(1'b1); // Cause sets it
      clr;
      fchk(1'b1); // Clear ignored
      @(posedge clk);
      cs <= 3'h0;
      clr;
      fchk(1'b0); // Cause gone and cleared
    end
    wr(fail_pkg::ADDR_CTRL, 32'h0);
    cs <= 3'h4;
    wt(4);
    fchk(1'b0); // Overvoltage without enable
    cs <= 3'h0;
    // Three detections, a good reading, then four in a row.
    for (int k = 0; k < 8; k++) begin
      pulse(k == 3 ? 6'h02 : 6'h04);
      wt(2);
      cmp_bit("fail_out", k != 7, fail_out); // Fourth in a row
    end
    pulse(6'h02);
    clr;
    fchk(1'b0); // Supply good and cleared
    rd(fail_pkg::ADDR_IRQ_STATUS, v);
    cmp_word("irq_status", 32'hF, v);
    rng = xs(rng);
    wr(fail_pkg::ADDR_IRQ_MASK, rng);
    wt(2);
    cmp_bit("irq", |rng[3:0], irq);
    rd(fail_pkg::ADDR_IRQ_MASK, v);
    cmp_word("irq_mask", {28'h0, rng[3:0]}, v);
    wr(fail_pkg::ADDR_IRQ_STATUS, 32'hF);
    wt(2);
    cmp_bit("irq", 1'b0, irq);
    // Events outside Normal or Stop are dropped; events during a pulse merge.
    pulses = 0;
    normal_or_stop <= 1'b0;
    pulse(6'h20);
    wt(2 * W);
    cmp_word("pulses", 32'h0, 32'(pulses)); // Dropped
    normal_or_stop <= 1'b1;
    pulse(6'h20);
    wt(2);
    cmp_bit("interrupt_out_n", 1'b0, interrupt_out_n);
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      wt(rng[2:0]);
      pulse(6'h20);
    end
    wt(4 * W);
    cmp_word("pulses", 32'h2, 32'(pulses)); // Merged
    close_out;
  end
endmodule
